// ---- ebi_core.sv ----
// external bus pin interface: apb registers, bus cycle engine and pins
// assumes all pin inputs are asynchronous and are synchronised here
//
// The register offsets and register access over APB were chosen for this implementation.
module ebi_core (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ready_in,
    input  wire logic        ext_access_sel_n,
    output logic             read_strobe_n,
    output logic             write_strobe_pin_n,
    output logic             addr_latch_strobe,
    output logic             ext_fetch,
    output ebi_pkg::ebi_pin8_t segment_address_port,
    output ebi_pkg::ebi_pin8_t address_data_port_low,
    output ebi_pkg::ebi_pin8_t address_data_port_high,
    output ebi_pkg::ebi_pin8_t demux_address_port_low,
    output ebi_pkg::ebi_pin8_t demux_address_port_high,
    input  wire logic [15:0] address_data_port_in
);
    ebi_pkg::ebi_state_reg_t s_q;
    ebi_pkg::ebi_state_reg_t s_d;

    logic bus_en;
    logic mux;
    logic bus16;
    logic low_byte_write_strobe_mode;
    logic rdy_en;
    logic busy;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic strobe_on;
    logic data_out;
    logic wr_qual;

    assign bus_en  = s_q.ctrl[ebi_pkg::CTRL_BUS_EN];
    assign mux     = s_q.ctrl[ebi_pkg::CTRL_MUX];
    assign bus16   = s_q.ctrl[ebi_pkg::CTRL_BUS16];
    assign low_byte_write_strobe_mode     = s_q.ctrl[ebi_pkg::CTRL_WRL];
    assign rdy_en  = s_q.ctrl[ebi_pkg::CTRL_RDY_EN];
    assign busy    = (s_q.st != ebi_pkg::ST_IDLE);
    assign acc     = psel && penable;
    assign wr_acc  = acc && pwrite;
    assign rd_acc  = acc && !pwrite;
    assign strobe_on = (s_q.st == ebi_pkg::ST_STROBE)
                     || (s_q.st == ebi_pkg::ST_WAIT);
    assign data_out  = s_q.wr && (strobe_on
                     || (s_q.st == ebi_pkg::ST_HOLD));
    // write strobe qualification by mode
    assign wr_qual = !low_byte_write_strobe_mode || !bus16 || s_q.lo;

    // merge a bus function onto a port half; gpio where not used
    function automatic ebi_pkg::ebi_pin8_t pin_mux(
        input logic       use_bus,
        input logic [7:0] bus_val,
        input logic       bus_oe,
        input logic [7:0] gp_val,
        input logic [7:0] gp_dir);
        ebi_pkg::ebi_pin8_t p;
        p.o  = use_bus ? bus_val : gp_val;
        p.oe = use_bus ? {8{bus_oe}} : gp_dir;
        return p;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rdy_s = {s_q.rdy_s[0], ready_in};
        s_d.ea_s  = {s_q.ea_s[0], ext_access_sel_n};
        s_d.d0_s1 = address_data_port_in;
        s_d.d0_s2 = s_q.d0_s1;
        s_d.prdata = 32'h0000_0000;
        // read word registered first, ready follows one cycle later
        s_d.rd_ack = rd_acc && !s_q.rd_ack;
        // external-access select sampled on the first cycle after reset
        if (!s_q.ea_seen) begin
            s_d.ext_fetch = !s_q.ea_s[1];
            s_d.ea_seen   = 1'b1;
        end
        if (wr_acc) begin
            unique case (paddr)
                ebi_pkg::ADDR_CTRL:  s_d.ctrl = pwdata[4:0];
                ebi_pkg::ADDR_ADDR:  s_d.addr = pwdata[23:0];
                ebi_pkg::ADDR_WDATA: s_d.wdata = pwdata[15:0];
                ebi_pkg::ADDR_DIR:   s_d.dir[31:0] = pwdata;
                ebi_pkg::ADDR_GPIO:  s_d.gpio[31:0] = pwdata;
                ebi_pkg::ADDR_PINS: begin
                    s_d.dir[39:32]  = pwdata[7:0];
                    s_d.gpio[39:32] = pwdata[15:8];
                end
                ebi_pkg::ADDR_CMD: begin
                    if (!busy && bus_en) begin
                        s_d.wr   = pwdata[ebi_pkg::CMD_WRITE];
                        s_d.hi   = pwdata[ebi_pkg::CMD_HIGH];
                        s_d.lo   = pwdata[ebi_pkg::CMD_LOW];
                        s_d.done = 1'b0;
                        s_d.cnt  = mux ? ebi_pkg::ALE_CYCLES
                                       : ebi_pkg::STROBE_CYCLES;
                        s_d.st   = mux ? ebi_pkg::ST_ALE
                                       : ebi_pkg::ST_STROBE;
                    end
                end
                default: ;
            endcase
        end
        if (rd_acc && !s_q.rd_ack) begin
            unique case (paddr)
                ebi_pkg::ADDR_CTRL:   s_d.prdata = {27'h0, s_q.ctrl};
                ebi_pkg::ADDR_ADDR:   s_d.prdata = {8'h00, s_q.addr};
                ebi_pkg::ADDR_WDATA:  s_d.prdata = {16'h0000, s_q.wdata};
                ebi_pkg::ADDR_RDATA:  s_d.prdata = {16'h0000, s_q.rdata};
                ebi_pkg::ADDR_STATUS: s_d.prdata = {28'h0, s_q.rdy_s[1],
                                        s_q.ext_fetch, s_q.done, busy};
                ebi_pkg::ADDR_DIR:    s_d.prdata = s_q.dir[31:0];
                ebi_pkg::ADDR_GPIO:   s_d.prdata = s_q.gpio[31:0];
                ebi_pkg::ADDR_PINS:   s_d.prdata = {16'h0000,
                                        s_q.gpio[39:32], s_q.dir[39:32]};
                default:              s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (bus_en && !mux) begin
            s_d.demux_seen = 1'b1;
            s_d.a_keep     = s_q.addr[15:0];
        end
        unique case (s_q.st)
            ebi_pkg::ST_IDLE: ;
            ebi_pkg::ST_ALE: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h1) begin
                    s_d.st  = ebi_pkg::ST_STROBE;
                    s_d.cnt = ebi_pkg::STROBE_CYCLES;
                end
            end
            ebi_pkg::ST_STROBE: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h1) begin
                    s_d.st = ebi_pkg::ST_WAIT;
                end
            end
            ebi_pkg::ST_WAIT: begin
                // waits while ready held high and rdy_en is set
                if (!(rdy_en && s_q.rdy_s[1])) begin
                    s_d.st = ebi_pkg::ST_HOLD;
                    if (!s_q.wr) begin
                        s_d.rdata = s_q.d0_s2;
                    end
                end
            end
            ebi_pkg::ST_HOLD: begin
                s_d.st   = ebi_pkg::ST_IDLE;
                s_d.done = 1'b1;
            end
            default: s_d.st = ebi_pkg::ST_IDLE;
        endcase
        if (rst) begin
            s_d = '0;
            s_d.st   = ebi_pkg::ST_IDLE;
            s_d.ctrl = ebi_pkg::CTRL_RESET;
            // synchronisers keep sampling so the strap is valid at release
            s_d.rdy_s = {s_q.rdy_s[0], ready_in};
            s_d.ea_s  = {s_q.ea_s[0], ext_access_sel_n};
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    logic [7:0] ad_lo;
    logic [7:0] ad_hi;
    logic       ad_lo_oe;
    logic       ad_hi_oe;
    logic       hi_bus;
    logic       addr_phase;

    assign addr_phase = (s_q.st == ebi_pkg::ST_ALE);
    // multiplexed: address in latch phase, data after; 8-bit mode keeps address on the high byte
    always_comb begin
        if (mux) begin
            ad_lo    = addr_phase ? s_q.addr[7:0] : s_q.wdata[7:0];
            ad_hi    = (addr_phase || !bus16) ? s_q.addr[15:8]
                                               : s_q.wdata[15:8];
            ad_lo_oe = addr_phase || data_out;
            ad_hi_oe = addr_phase || data_out || (busy && !bus16);
        end else begin
            ad_lo    = s_q.wdata[7:0];
            ad_hi    = s_q.wdata[15:8];
            ad_lo_oe = data_out;
            ad_hi_oe = data_out;
        end
    end
    assign hi_bus = bus_en && (mux || bus16);

    assign segment_address_port = pin_mux(bus_en, s_q.addr[23:16], 1'b1,
        s_q.gpio[7:0], s_q.dir[7:0]);
    assign address_data_port_low = pin_mux(bus_en, ad_lo, ad_lo_oe,
        s_q.gpio[15:8], s_q.dir[15:8]);
    assign address_data_port_high = pin_mux(hi_bus, ad_hi, ad_hi_oe,
        s_q.gpio[23:16], s_q.dir[23:16]);
    assign demux_address_port_low = pin_mux(s_q.demux_seen,
        s_q.a_keep[7:0], 1'b1, s_q.gpio[31:24], s_q.dir[31:24]);
    assign demux_address_port_high = pin_mux(s_q.demux_seen,
        s_q.a_keep[15:8], 1'b1, s_q.gpio[39:32], s_q.dir[39:32]);

    assign read_strobe_n      = !(strobe_on && !s_q.wr);
    assign write_strobe_pin_n = !(strobe_on && s_q.wr && wr_qual);
    assign addr_latch_strobe  = addr_phase && mux;
    assign ext_fetch          = s_q.ext_fetch;
    assign prdata             = s_q.prdata;
    assign pready             = !rd_acc || s_q.rd_ack;
    assign pslverr            = 1'b0;
endmodule

// ---- ebi_core_checker.sv ----
// checker for ebi_core: strobe, latch and pin-direction relations
// assumes it is bound to the core and sees only its ports
module ebi_core_checker (
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               read_strobe_n,
    input wire logic               write_strobe_pin_n,
    input wire logic               addr_latch_strobe,
    input wire ebi_pkg::ebi_pin8_t segment_address_port,
    input wire ebi_pkg::ebi_pin8_t address_data_port_low
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_rw_excl: assert property (read_strobe_n || write_strobe_pin_n)
        else $error("read and write strobes low together");
    a_ale_pulse: assert property (addr_latch_strobe |=> !addr_latch_strobe)
        else $error("latch strobe longer than one cycle");
    a_ale_addr: assert property (addr_latch_strobe |->
        address_data_port_low.oe == 8'hFF) else $error("address not driven");
    a_rd_min: assert property ($fell(read_strobe_n) |->
        !read_strobe_n [*3]) else $error("read strobe too short");
    a_rd_bound: assert property ($fell(read_strobe_n) |->
        ##[3:40] read_strobe_n) else $error("read strobe never ends");
    a_wr_min: assert property ($fell(write_strobe_pin_n) |->
        !write_strobe_pin_n [*3]) else $error("write strobe too short");
    a_rd_release: assert property (!read_strobe_n |->
        address_data_port_low.oe == 8'h00) else $error("bus driven in read");
    a_wr_drive: assert property (!write_strobe_pin_n |->
        address_data_port_low.oe == 8'hFF) else $error("data not driven");
    a_reset_idle: assert property ($fell(rst) |-> read_strobe_n &&
        write_strobe_pin_n && !addr_latch_strobe &&
        segment_address_port.oe == 8'h00) else $error("not idle after reset");
endmodule

bind ebi_core ebi_core_checker ebi_core_checker_inst (
    .mclk(mclk), .rst(rst), .read_strobe_n(read_strobe_n),
    .write_strobe_pin_n(write_strobe_pin_n),
    .addr_latch_strobe(addr_latch_strobe),
    .segment_address_port(segment_address_port),
    .address_data_port_low(address_data_port_low)
);

// ---- ebi_mem_model.sv ----
// external memory on the multiplexed bus: latches, captures, waits
// assumes strobes active low and pins given as output plus enable
module ebi_mem_model (
    input wire logic               mclk,
    input wire logic               rd_n,
    input wire logic               wr_n,
    input wire logic               ale,
    input wire ebi_pkg::ebi_pin8_t adl,
    input wire ebi_pkg::ebi_pin8_t adh,
    input wire logic [15:0]        rd_word,
    input wire logic [3:0]         waits,
    output logic                   ready_in,
    output logic [15:0]            pins,
    output logic [15:0]            lat_a,
    output logic [15:0]            wr_d,
    output int                     wr_cnt = 0,
    output int                     rd_len = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last = 16'h0000;
    logic        rd_q = 1'h1;
    logic        wr_q = 1'h1;
    int          wc   = 0;
    // released lines show rd_word while rd_n is low, else the inverse of their last level
    assign pins = ({adh.o, adl.o} & {adh.oe, adl.oe}) |
                  ((rd_n ? ~last : rd_word) & ~{adh.oe, adl.oe});
    // ready raised with the strobe so it clears the sync delay
    assign ready_in = (!rd_n || !wr_n) && wc < waits;
    always @(posedge mclk) begin
        last <= pins;
        rd_q <= rd_n;
        wr_q <= wr_n;
        if (ale)
            lat_a <= pins;
        if (!wr_n)
            wr_d <= pins;
        if (!wr_n && wr_q)
            wr_cnt <= wr_cnt + 1;
        if (!rd_n)
            rd_len <= rd_q ? 1 : rd_len + 1;
        wc <= (rd_n && wr_n) ? 0 : wc + 1;
    end
endmodule

// ---- ebi_pkg.sv ----
// package for the external bus pin interface: constants, types, states
// assumes an apb slave at 50 mhz with a synchronous active-high reset
package ebi_pkg;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_ADDR   = 12'h004;
    localparam logic [11:0] ADDR_WDATA  = 12'h008;
    localparam logic [11:0] ADDR_RDATA  = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_DIR    = 12'h014;
    localparam logic [11:0] ADDR_GPIO   = 12'h018;
    localparam logic [11:0] ADDR_PINS   = 12'h01C;
    localparam logic [11:0] ADDR_CMD    = 12'h020;

    // ctrl bit positions
    localparam int CTRL_BUS_EN  = 0;
    localparam int CTRL_MUX     = 1;
    localparam int CTRL_BUS16   = 2;
    localparam int CTRL_WRL     = 3;
    localparam int CTRL_RDY_EN  = 4;
    localparam int CTRL_W       = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // cmd register bits
    localparam int CMD_WRITE = 0;
    localparam int CMD_HIGH  = 1;
    localparam int CMD_LOW   = 2;

    // phase lengths in cycles
    localparam logic [3:0] ALE_CYCLES    = 4'h1;
    localparam logic [3:0] STROBE_CYCLES = 4'h2;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_ALE    = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_WAIT   = 5'b01000,
        ST_HOLD   = 5'b10000
    } ebi_state_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } ebi_pin8_t;

    typedef struct packed {
        ebi_state_t  st;
        logic [3:0]  cnt;
        logic [4:0]  ctrl;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        wr;
        logic        hi;
        logic        lo;
        logic        done;
        logic        ext_fetch;
        logic        ea_seen;
        logic [39:0] dir;
        logic [39:0] gpio;
        logic [15:0] a_keep;
        logic        demux_seen;
        logic [31:0] prdata;
        logic        rd_ack;
        logic [1:0]  rdy_s;
        logic [1:0]  ea_s;
        logic [15:0] d0_s1;
        logic [15:0] d0_s2;
    } ebi_state_reg_t;
endpackage

// ---- tb_top.sv ----
// testbench for ebi_core: apb tasks start bus cycles, model answers
// assumes ebi_pkg and ebi_mem_model are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic               pwrite = 1'h0, pready, pslverr, ready_in;
    logic               rd_n, wr_n, ale, xf, ea_n = 1'h0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, q;
    logic [15:0]        pins, lat_a, wr_d, cap_da, rd_word = 16'hC3A6;
    logic [7:0]         cap_seg;
    logic [3:0]         waits = 4'h0;
    ebi_pkg::ebi_pin8_t seg, adl, adh, dal, dah;
    int                 err_total = 0, n_checks = 0, wr_cnt, rd_len, c0;
    logic [7:0]         mode [5] = '{8'h0F, 8'h0F, 8'h0B, 8'h07, 8'h03};
    logic [2:0]         cmd [5] = '{3'h3, 3'h5, 3'h5, 3'h5, 3'h5};
    logic [15:0]        inc [5] = '{16'h0, 16'h1, 16'h1, 16'h1, 16'h1};

    ebi_core ebi_core_inst (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ready_in(ready_in), .ext_access_sel_n(ea_n),
        .read_strobe_n(rd_n), .write_strobe_pin_n(wr_n),
        .addr_latch_strobe(ale), .ext_fetch(xf), .segment_address_port(seg),
        .address_data_port_low(adl), .address_data_port_high(adh),
        .demux_address_port_low(dal), .demux_address_port_high(dah),
        .address_data_port_in(pins));
    ebi_mem_model ebi_mem_model_inst (.mclk(mclk), .rd_n(rd_n), .wr_n(wr_n),
        .ale(ale), .adl(adl), .adh(adh), .rd_word(rd_word), .waits(waits),
        .ready_in(ready_in), .pins(pins), .lat_a(lat_a), .wr_d(wr_d),
        .wr_cnt(wr_cnt), .rd_len(rd_len));

    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        if (!wr_n) begin
            cap_seg <= seg.o;
            cap_da <= {dah.o, dal.o};
        end
    end

    task automatic finish_test();
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, s);
        n_checks++;
        if (s !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, s);
            err_total++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) begin
            err_total++;
            finish_test();
        end
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic op(input logic [23:0] a, input logic [15:0] d,
                      input logic [2:0] c);
        int n = 0;
        apb(1'h1, ebi_pkg::ADDR_ADDR, {8'h00, a});
        apb(1'h1, ebi_pkg::ADDR_WDATA, {16'h0000, d});
        apb(1'h1, ebi_pkg::ADDR_CMD, {29'h0, c});
        do begin
            apb(1'h0, ebi_pkg::ADDR_STATUS, 0);
            n++;
        end while (q[0] !== 1'h0 && n < 40);
        if (n >= 40) begin
            err_total++;
            finish_test();
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        #1 chk("ext_fetch", 16'h1, {15'h0, xf});
        chk("seg_oe", 16'h0, {8'h0, seg.oe});
        apb(1'h1, ebi_pkg::ADDR_GPIO, 32'hA5);
        apb(1'h1, ebi_pkg::ADDR_DIR, 32'h0F);
        @(posedge mclk);
        #1 chk("seg_pins", 16'h050F, {seg.o & seg.oe, seg.oe});
        apb(1'h1, ebi_pkg::ADDR_CTRL, 32'h07);
        op(24'h5A1234, 16'hBEEF, 3'h7);
        chk("mux_addr", 16'h1234, lat_a);
        chk("wr_data", 16'hBEEF, wr_d);
        chk("seg_addr", 16'h005A, {8'h00, cap_seg});
        apb(1'h1, ebi_pkg::ADDR_CTRL, 32'h17);
        waits <= 4'h4;
        op(24'h5A0010, 16'h0000, 3'h6);
        apb(1'h0, ebi_pkg::ADDR_RDATA, 0);
        chk("rd_data", 16'hC3A6, q[15:0]);
        chk("rd_wait", 16'h1, {15'h0, rd_len > 4});
        waits <= 4'h0;
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, ebi_pkg::ADDR_CTRL, {24'h0, mode[i]});
            c0 = wr_cnt;
            op(24'h000042, 16'h1234, cmd[i]);
            chk("wr_count", inc[i], 16'(wr_cnt - c0));
            chk("mux_addr", 16'h0042, lat_a);
        end
        apb(1'h1, ebi_pkg::ADDR_CTRL, 32'h05);
        op(24'h3C4321, 16'h7E81, 3'h7);
        chk("demux_addr", 16'h4321, cap_da);
        chk("demux_data", 16'h7E81, wr_d);
        apb(1'h1, ebi_pkg::ADDR_CTRL, 32'h07);
        op(24'h001111, 16'h2222, 3'h7);
        chk("addr_keep", 16'hFFFF, {dah.oe, dal.oe});
        chk("addr_keep_val", 16'h4321, {dah.o, dal.o});
        chk("mux_addr", 16'h1111, lat_a);
        apb(1'h0, 12'h030, 0);
        chk("unmapped", 16'h0000, q[15:0]);
        ea_n <= 1'h1;
        rst <= 1'h1;
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        #1 chk("ext_fetch", 16'h0, {15'h0, xf});
        chk("addr_oe", 16'h0000, {dah.oe, dal.oe});
        finish_test();
    end
endmodule
